//--- bench/data_memory_model.sv
// Purpose: data memory seen through the indirect window
// Assumes: reads answered in the same cycle
// Notes: idle read data shows the inverse of the last value
module data_memory_model
	import flow_pkg::*;
(
	input wire logic ref_clk,
	input wire flow_pkg::mem_req_t mem_req,
	output logic [7:0] mem_rdata
);
	logic [7:0] last_r = 8'h5a;
	// remember the last value handed out
	always_ff @(posedge ref_clk) begin
		if (mem_req.rd) begin
			last_r <= mem_rdata;
		end
	end
	// cell contents derived from the address; idle bus is not data
	assign mem_rdata = mem_req.rd ? (mem_req.addr[7:0] ^ {mem_req.addr[8], 7'h2a}) : ~last_r;
endmodule : data_memory_model

//--- bench/program_flow_and_irq_control_asserts.sv
// Purpose: port-level checks of program flow and interrupt control
// Assumes: one clock, sync active-high reset
// Notes: attached by bind at the foot of this file
module flow_checker
	import flow_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire flow_pkg::pc_op_t pc_op,
	input wire logic [10:0] jump_field,
	input wire flow_pkg::file_req_t file_req,
	input wire logic indirect_bank_bit,
	input wire logic [7:0] mem_rdata,
	input wire flow_pkg::mem_req_t mem_req,
	input wire logic [7:0] file_rdata,
	input wire logic [12:0] pc,
	input wire logic irq_request
);
	// one clock domain for all checks
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// steps of a call followed by a return, and a window read
	sequence s_call;
		pc_op == PC_CALL && !file_req.wr;
	endsequence
	sequence s_ret;
		pc_op == PC_RET && !file_req.wr;
	endsequence
	sequence s_win_rd;
		file_req.rd && file_req.addr[6:0] == ADDR_WINDOW;
	endsequence
	property p_reset;
		disable iff (1'b0) sys_rst |=> pc == RESET_VECTOR && !irq_request;
	endproperty
	property p_step;
		pc_op == PC_STEP && !file_req.wr |=> pc == $past(pc) + 13'h0001;
	endproperty
	property p_jump;
		pc_op == PC_JUMP && !file_req.wr |=> pc[10:0] == $past(jump_field);
	endproperty
	property p_irq_vec;
		pc_op == PC_IRQ && !file_req.wr |=> pc == IRQ_VECTOR;
	endproperty
	property p_call_ret;
		s_call ##1 s_ret |=> pc == $past(pc, 2) + 13'h0001;
	endproperty
	property p_low;
		file_req.wr && file_req.addr[6:0] == ADDR_LOW_BYTE |=> pc[7:0] == $past(file_req.wdata);
	endproperty
	property p_gie_off;
		file_req.wr && file_req.addr[6:0] == ADDR_IRQ_CONTROL && !file_req.wdata[GIE_BIT]
			|=> !irq_request;
	endproperty
	property p_win_data;
		s_win_rd |-> file_rdata == (mem_req.rd ? mem_rdata : ZERO_BYTE);
	endproperty
	property p_win_addr;
		s_win_rd |-> mem_req.addr[8] == indirect_bank_bit
			&& mem_req.rd == (mem_req.addr[6:0] != 7'h00);
	endproperty
	a_reset: assert property (p_reset) else $error("counter not cleared by reset");
	a_step: assert property (p_step) else $error("counter did not advance");
	a_jump: assert property (p_jump) else $error("jump field not loaded");
	a_irq_vec: assert property (p_irq_vec) else $error("vector not loaded");
	a_call_ret: assert property (p_call_ret) else $error("return address wrong");
	a_low: assert property (p_low) else $error("low byte not loaded");
	a_gie_off: assert property (p_gie_off) else $error("request with global off");
	a_win_data: assert property (p_win_data) else $error("window data wrong");
	a_win_addr: assert property (p_win_addr) else $error("window address wrong");
endmodule : flow_checker

bind program_flow_and_irq_control flow_checker flow_checker_inst (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.pc_op(pc_op),
	.jump_field(jump_field),
	.file_req(file_req),
	.indirect_bank_bit(indirect_bank_bit),
	.mem_rdata(mem_rdata),
	.mem_req(mem_req),
	.file_rdata(file_rdata),
	.pc(pc),
	.irq_request(irq_request)
);

//--- bench/tb_program_flow_and_irq_control.sv
// Purpose: self-checking bench for program flow and interrupt control
// Assumes: inputs change 2 ns after the rising edge
// Notes: random counter and pointer values from a fixed seed
module tb_program_flow_and_irq_control
	import flow_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	pc_op_t pc_op = PC_HOLD;
	logic [10:0] jump_field = 11'h000;
	file_req_t file_req = '0;
	logic indirect_bank_bit = 1'b0;
	irq_events_t events = '0;
	logic [7:0] mem_rdata, file_rdata, d, p;
	mem_req_t mem_req;
	logic file_hit, irq_request;
	logic [12:0] pc, e;
	logic [4:0] lat;
	logic [12:0] q [$];
	int num_errors = 0;
	int n_compared = 0;
	// clock and instances
	always #12.5 ref_clk = ~ref_clk;
	program_flow_and_irq_control program_flow_and_irq_control_inst (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .pc_op(pc_op), .jump_field(jump_field), .file_req(file_req),
		.indirect_bank_bit(indirect_bank_bit), .events(events), .mem_rdata(mem_rdata),
		.mem_req(mem_req), .file_rdata(file_rdata), .file_hit(file_hit), .pc(pc),
		.irq_request(irq_request));
	data_memory_model data_memory_model_inst (.ref_clk(ref_clk), .mem_req(mem_req),
		.mem_rdata(mem_rdata));
	// helpers
	function automatic logic [7:0] mem_expect(logic [8:0] a);
		return a[7:0] ^ {a[8], 7'h2a};
	endfunction : mem_expect
	task automatic chk(string n, logic [15:0] s, logic [15:0] x);
		n_compared++;
		if (s !== x) begin
			$display("wrong value %s expected %h seen %h", n, x, s);
			num_errors++;
		end
	endtask : chk
	task automatic cyc(pc_op_t o, logic [1:0] rw, logic [7:0] a, logic [7:0] v, logic [10:0] ev);
		@(posedge ref_clk);
		#2;
		pc_op = o;
		file_req = '{rw[1], rw[0], a, v};
		events = irq_events_t'(ev);
		jump_field = 11'($urandom);
		indirect_bank_bit = 1'($urandom);
		#1;
	endtask : cyc
	task automatic complete_run();
		if (num_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	// hang guard
	initial begin
		#50000;
		num_errors++;
		complete_run();
	end
	// main sequence
	initial begin
		void'($urandom(71));
		repeat (4) @(posedge ref_clk);
		#2;
		sys_rst = 1'b0;
		cyc(PC_HOLD, 2'b10, 8'h0b, 8'h00, 11'h000);
		chk("pc", pc, 13'h0000);
		chk("control", file_rdata, CONTROL_RST);
		for (int i = 0; i < 3; i++) begin
			cyc(PC_HOLD, 2'b01, 8'h8b, 8'h20 >> i, 11'h000);
			cyc(PC_HOLD, 2'b00, 8'h00, 8'h00, 11'h400 >> i);
			cyc(PC_HOLD, 2'b10, 8'h0b, 8'h00, 11'h000);
			chk("flags", file_rdata, (8'h20 >> i) | (8'h04 >> i));
			chk("irq", irq_request, 1'b0);
			cyc(PC_HOLD, 2'b01, 8'h0b, 8'h80 | (8'h20 >> i) | (8'h04 >> i), 11'h000);
			cyc(PC_HOLD, 2'b01, 8'h0b, 8'h00, 11'h000);
			chk("irq", irq_request, 1'b1);
		end
		cyc(PC_HOLD, 2'b01, 8'h8c, 8'hff, 11'h000);
		cyc(PC_HOLD, 2'b01, 8'h0b, 8'h80, 11'h040);
		cyc(PC_HOLD, 2'b10, 8'h8c, 8'h00, 11'h000);
		chk("enables", file_rdata, 8'h40);
		cyc(PC_HOLD, 2'b10, 8'h0c, 8'h00, 11'h000);
		chk("pflags", file_rdata, 8'h40);
		chk("irq", irq_request, 1'b0);
		cyc(PC_HOLD, 2'b01, 8'h0b, 8'hc0, 11'h000);
		cyc(PC_HOLD, 2'b01, 8'h0b, 8'h00, 11'h000);
		chk("irq", irq_request, 1'b1);
		lat = 5'($urandom);
		d = 8'($urandom);
		cyc(PC_HOLD, 2'b01, 8'h8a, {3'h0, lat}, 11'h000);
		cyc(PC_HOLD, 2'b01, 8'h02, d, 11'h000);
		e = {lat, d};
		// nine calls wrap the eight-deep stack, then eight returns
		for (int k = 0; k < 9; k++) begin
			cyc(PC_CALL, 2'b00, 8'h00, 8'h00, 11'h000);
			chk("pc", pc, e);
			q.push_back(e + 13'h0001);
			e = {lat[4:3], jump_field};
		end
		for (int k = 0; k < 8; k++) begin
			cyc(PC_RET, 2'b00, 8'h00, 8'h00, 11'h000);
			chk("pc", pc, e);
			e = q[8 - k];
		end
		cyc(PC_JUMP, 2'b00, 8'h00, 8'h00, 11'h000);
		chk("pc", pc, e);
		e = {lat[4:3], jump_field};
		cyc(PC_IRQ, 2'b00, 8'h00, 8'h00, 11'h000);
		chk("pc", pc, e);
		cyc(PC_STEP, 2'b10, 8'h0a, 8'h00, 11'h000);
		chk("pc", pc, IRQ_VECTOR);
		chk("latch", file_rdata, {3'h0, lat});
		cyc(PC_HOLD, 2'b01, 8'h04, 8'h00, 11'h000);
		chk("pc", pc, 13'h0005);
		cyc(PC_HOLD, 2'b10, 8'h80, 8'h00, 11'h000);
		chk("window", file_rdata, 8'h00);
		chk("mem rd", mem_req.rd, 1'b0);
		p = 8'($urandom) | 8'h01;
		cyc(PC_HOLD, 2'b01, 8'h84, p, 11'h000);
		cyc(PC_HOLD, 2'b10, 8'h00, 8'h00, 11'h000);
		chk("window", file_rdata, mem_expect({indirect_bank_bit, p}));
		// window write goes out through the pointer
		d = 8'($urandom);
		cyc(PC_HOLD, 2'b01, 8'h80, d, 11'h000);
		chk("mem wr", mem_req.wr, 1'b1);
		chk("mem addr", mem_req.addr, {indirect_bank_bit, p});
		chk("mem data", mem_req.wdata, d);
		// pointer at the window itself: write is dropped
		cyc(PC_HOLD, 2'b01, 8'h04, 8'h80, 11'h000);
		cyc(PC_HOLD, 2'b01, 8'h00, d, 11'h000);
		chk("mem wr", mem_req.wr, 1'b0);
		cyc(PC_HOLD, 2'b10, 8'h0d, 8'h00, 11'h000);
		chk("hit", file_hit, 1'b0);
		// low byte write beats a step, event beats a clearing write
		cyc(PC_STEP, 2'b01, 8'h02, 8'h40, 11'h000);
		cyc(PC_HOLD, 2'b01, 8'h0b, 8'h00, 11'h400);
		chk("pc", pc, {lat, 8'h40});
		cyc(PC_HOLD, 2'b10, 8'h0b, 8'h00, 11'h000);
		chk("flags", file_rdata, 8'h04);
		complete_run();
	end
endmodule : tb_program_flow_and_irq_control

//--- src/flow_pkg.sv
// Purpose: constants and carrier types for the program flow and interrupt control block
// Assumes: one instruction clock, synchronous active-high reset
// Notes: file-register addresses are 8-bit bank-qualified locations of the data bus
package flow_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int PC_W = 13;
	localparam int SP_W = 3;
	localparam int STACK_DEPTH = 8;
	localparam int IND_W = 9;
	localparam int PAGE_W = 11; // address field of a call or jump

	// ----------------------------------------
	// register addresses (low 7 bits mirrored across banks where noted)
	// ----------------------------------------
	localparam logic [6:0] ADDR_WINDOW = 7'h00;
	localparam logic [6:0] ADDR_LOW_BYTE = 7'h02;
	localparam logic [6:0] ADDR_POINTER = 7'h04;
	localparam logic [6:0] ADDR_HIGH_LATCH = 7'h0a;
	localparam logic [6:0] ADDR_IRQ_CONTROL = 7'h0b;
	localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_PERIPH_ENABLES = 8'h8c;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int GIE_BIT = 7;
	localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
	localparam int TIMER_OVERFLOW_ENABLE_BIT = 5;
	localparam int EXT_PIN_IRQ_ENABLE_BIT = 4;
	localparam int PORT_CHANGE_ENABLE_BIT = 3;
	localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
	localparam int EXT_PIN_IRQ_FLAG_BIT = 1;
	localparam int PORT_CHANGE_FLAG_BIT = 0;
	localparam int LATCH_W = 5;
	localparam int PAGE_LO = 3; // latch bits 4:3 are page selects

	// ----------------------------------------
	// reset values and vectors
	// ----------------------------------------
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] PERIPH_RST = 8'h00;
	localparam logic [7:0] PERIPH_MASK = 8'h40; // only bit 6 implemented
	localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
	localparam logic [7:0] POINTER_RST = 8'h00;
	localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------
	// program counter operations from decode
	// ----------------------------------------
	typedef enum logic [2:0] {
		PC_HOLD = 3'b000,
		PC_STEP = 3'b001,
		PC_JUMP = 3'b010,
		PC_CALL = 3'b011,
		PC_RET = 3'b100,
		PC_IRQ = 3'b101
	} pc_op_t;

	// file register access from execution
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr; // bank bit in bit 7
		logic [7:0] wdata;
	} file_req_t;

	// request toward data memory
	typedef struct packed {
		logic rd;
		logic wr;
		logic [IND_W-1:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	// interrupt event pulses
	typedef struct packed {
		logic timer_overflow;
		logic ext_pin;
		logic port_change;
		logic [7:0] periph;
	} irq_events_t;
endpackage : flow_pkg

//--- src/program_flow_and_irq_control.sv
// Purpose: program counter, return stack, indirect addressing and interrupt control
// Assumes: decode drives one pc_op per instruction cycle; ref_clk is the instruction clock
// Notes: data memory answers reads in the same cycle (mem_rdata combinational)
module program_flow_and_irq_control (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire flow_pkg::pc_op_t pc_op,
	input wire logic [flow_pkg::PAGE_W-1:0] jump_field,
	input wire flow_pkg::file_req_t file_req,
	input wire logic indirect_bank_bit,
	input wire flow_pkg::irq_events_t events,
	input wire logic [7:0] mem_rdata,
	output flow_pkg::mem_req_t mem_req,
	output logic [7:0] file_rdata,
	output logic file_hit,
	output logic [flow_pkg::PC_W-1:0] pc,
	output logic irq_request
);
	import flow_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pc_nxt;
	logic [LATCH_W-1:0] counter_high_latch_r;
	logic [7:0] core_irq_control_r;
	logic [7:0] peripheral_irq_flags_r;
	logic [7:0] peripheral_irq_enables_r;
	logic [7:0] indirect_pointer_r;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [SP_W-1:0] sp_r;
	logic [SP_W-1:0] pop_idx;

	// decoded accesses
	logic is_window;
	logic hit_low, hit_latch, hit_ctrl, hit_pflags, hit_pen, hit_ptr;
	logic wr_low, wr_latch, wr_ctrl, wr_pflags, wr_pen, wr_ptr;
	logic ind_self;
	logic periph_pending;
	logic [7:0] ctrl_set;

	assign pop_idx = sp_r - SP_W'(1);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	always_comb begin
		is_window = 1'b0;
		hit_low = 1'b0;
		hit_latch = 1'b0;
		hit_ctrl = 1'b0;
		hit_pflags = 1'b0;
		hit_pen = 1'b0;
		hit_ptr = 1'b0;
		if (file_req.addr[6:0] == ADDR_WINDOW) begin
			is_window = 1'b1;
		end else if (file_req.addr[6:0] == ADDR_LOW_BYTE) begin
			hit_low = 1'b1;
		end else if (file_req.addr[6:0] == ADDR_POINTER) begin
			hit_ptr = 1'b1;
		end else if (file_req.addr[6:0] == ADDR_HIGH_LATCH) begin
			hit_latch = 1'b1;
		end else if (file_req.addr[6:0] == ADDR_IRQ_CONTROL) begin
			hit_ctrl = 1'b1;
		end else if (file_req.addr == ADDR_PERIPH_FLAGS) begin
			hit_pflags = 1'b1;
		end else if (file_req.addr == ADDR_PERIPH_ENABLES) begin
			hit_pen = 1'b1;
		end
	end

	assign wr_low = file_req.wr & hit_low;
	assign wr_latch = file_req.wr & hit_latch;
	assign wr_ctrl = file_req.wr & hit_ctrl;
	assign wr_pflags = file_req.wr & hit_pflags;
	assign wr_pen = file_req.wr & hit_pen;
	assign wr_ptr = file_req.wr & hit_ptr;
	assign ind_self = (indirect_pointer_r[6:0] == ADDR_WINDOW);

	// ----------------------------------------
	// indirect path to data memory
	// ----------------------------------------
	// window access becomes a memory access at bank bit plus pointer, unless the pointer selects the window itself
	always_comb begin
		mem_req.rd = file_req.rd & is_window & ~ind_self;
		mem_req.wr = file_req.wr & is_window & ~ind_self;
		mem_req.addr = {indirect_bank_bit, indirect_pointer_r};
		mem_req.wdata = file_req.wdata;
	end

	// ----------------------------------------
	// read data mux
	// ----------------------------------------
	always_comb begin
		file_rdata = ZERO_BYTE;
		file_hit = is_window | hit_low | hit_latch | hit_ctrl | hit_pflags | hit_pen | hit_ptr;
		if (is_window) begin
			file_rdata = ind_self ? ZERO_BYTE : mem_rdata;
		end else if (hit_low) begin
			file_rdata = pc_r[7:0];
		end else if (hit_latch) begin
			file_rdata = {3'b000, counter_high_latch_r};
		end else if (hit_ctrl) begin
			file_rdata = core_irq_control_r;
		end else if (hit_pflags) begin
			file_rdata = peripheral_irq_flags_r;
		end else if (hit_pen) begin
			file_rdata = peripheral_irq_enables_r;
		end else if (hit_ptr) begin
			file_rdata = indirect_pointer_r;
		end
	end

	// ----------------------------------------
	// program counter
	// ----------------------------------------
	// upper bits come from the latch or the stack, are cleared by the vector, and take the carry of a step
	always_comb begin
		pc_nxt = pc_r;
		case (pc_op)
			PC_STEP: pc_nxt = pc_r + PC_W'(1);
			PC_JUMP, PC_CALL: begin
				// page bits 4:3 of the latch give pc bits 12:11, one of four pages
				pc_nxt = {counter_high_latch_r[LATCH_W-1:PAGE_LO], jump_field};
			end
			PC_RET: pc_nxt = stack_mem[pop_idx];
			PC_IRQ: pc_nxt = IRQ_VECTOR;
			default: pc_nxt = pc_r;
		endcase
		if (wr_low) begin
			pc_nxt = {counter_high_latch_r, file_req.wdata};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pc_r <= RESET_VECTOR;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	assign pc = pc_r;

	// ----------------------------------------
	// holding latch
	// ----------------------------------------
	// written only by software; stack traffic does not touch it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			counter_high_latch_r <= LATCH_RST;
		end else if (wr_latch) begin
			counter_high_latch_r <= file_req.wdata[LATCH_W-1:0];
		end
	end

	// ----------------------------------------
	// return stack
	// ----------------------------------------
	// pointer wraps freely, oldest entry overwritten, no status
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sp_r <= '0;
		end else if (pc_op == PC_CALL || pc_op == PC_IRQ) begin
			sp_r <= sp_r + SP_W'(1);
		end else if (pc_op == PC_RET) begin
			sp_r <= pop_idx;
		end
	end

	// entries hold the return address; not part of any address space
	always_ff @(posedge ref_clk) begin
		if (pc_op == PC_CALL) begin
			stack_mem[sp_r] <= pc_r + PC_W'(1);
		end else if (pc_op == PC_IRQ) begin
			stack_mem[sp_r] <= pc_r;
		end
	end

	// ----------------------------------------
	// indirect pointer
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			indirect_pointer_r <= POINTER_RST;
		end else if (wr_ptr) begin
			indirect_pointer_r <= file_req.wdata;
		end
	end

	// ----------------------------------------
	// interrupt control register
	// ----------------------------------------
	// event sets win over a simultaneous software write
	always_comb begin
		ctrl_set = ZERO_BYTE;
		ctrl_set[TIMER_OVERFLOW_FLAG_BIT] = events.timer_overflow;
		ctrl_set[EXT_PIN_IRQ_FLAG_BIT] = events.ext_pin;
		ctrl_set[PORT_CHANGE_FLAG_BIT] = events.port_change;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			core_irq_control_r <= CONTROL_RST;
		end else if (wr_ctrl) begin
			core_irq_control_r <= file_req.wdata | ctrl_set;
		end else begin
			core_irq_control_r <= core_irq_control_r | ctrl_set;
		end
	end

	// ----------------------------------------
	// peripheral flags and enables
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			peripheral_irq_flags_r <= PERIPH_RST;
		end else if (wr_pflags) begin
			peripheral_irq_flags_r <= (file_req.wdata | events.periph) & PERIPH_MASK;
		end else begin
			peripheral_irq_flags_r <= (peripheral_irq_flags_r | events.periph) & PERIPH_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			peripheral_irq_enables_r <= PERIPH_RST;
		end else if (wr_pen) begin
			peripheral_irq_enables_r <= file_req.wdata & PERIPH_MASK;
		end
	end

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	assign periph_pending = core_irq_control_r[PERIPHERAL_GROUP_ENABLE_BIT]
		& |(peripheral_irq_flags_r & peripheral_irq_enables_r);

	// flag and own enable, then global gate
	assign irq_request = core_irq_control_r[GIE_BIT] & (
		(core_irq_control_r[TIMER_OVERFLOW_ENABLE_BIT] & core_irq_control_r[TIMER_OVERFLOW_FLAG_BIT])
		| (core_irq_control_r[EXT_PIN_IRQ_ENABLE_BIT] & core_irq_control_r[EXT_PIN_IRQ_FLAG_BIT])
		| (core_irq_control_r[PORT_CHANGE_ENABLE_BIT] & core_irq_control_r[PORT_CHANGE_FLAG_BIT])
		| periph_pending);
endmodule : program_flow_and_irq_control
